// ==== basic_interval_timer.sv ====
// Purpose: 8-bit basic interval timer with oscillation stabilization wait.
// Assumes: clk_i is the selected system oscillator clock; classic Wishbone registers.
// Notes:   Tap dividers are parameters so a simulation can shorten long waits.
//
// Summary of operation
// - One interval is 256 selected tap pulses.
// - Counter advances once per selected tap pulse.
// - FFH wraps to 00H, sets flag, keeps counting.
// - Restart bit clears counter, flag; self-clears.
// - Select codes pick divider and wait length.
// - Interrupt period equals selected stabilization time.
// - Interrupt wake from power-down holds clock.
// - Reset applies the 2^17-cycle standard wait.
// - Counter is read whole, read-only.

`timescale 1ns/10ps

module basic_interval_timer #(
  parameter int unsigned TAP_000_LOG2 = 12,
  parameter int unsigned TAP_011_LOG2 = 9,
  parameter int unsigned TAP_101_LOG2 = 7,
  parameter int unsigned TAP_111_LOG2 = 5
) (
  input  wire logic                                  clk_i,
  input  wire logic                                  rst_i,
  input  wire basic_interval_timer_pkg::wb_req_t     wb_req_i,
  output logic                                       wb_ack_o,
  output logic [basic_interval_timer_pkg::WB_DW-1:0] wb_dat_o,
  input  wire logic                                  stop_mode_i,
  input  wire logic                                  wake_irq_i,
  input  wire logic                                  interval_irq_ack_i,
  output logic                                       interval_irq_flag_o,
  output logic                                       sys_clk_hold_o,
  output logic                                       irq_o
);

  import basic_interval_timer_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.

  if (TAP_000_LOG2 < 1 || TAP_000_LOG2 > PRESC_W ||
      TAP_011_LOG2 < 1 || TAP_011_LOG2 > PRESC_W ||
      TAP_101_LOG2 < 1 || TAP_101_LOG2 > PRESC_W ||
      TAP_111_LOG2 < 1 || TAP_111_LOG2 > PRESC_W) begin : g_bad_tap
    $error("Tap divider exponents must lie between 1 and the prescaler width.");
  end

  // The exponent travels in LG_W bits, so it must be able to hold PRESC_W.
  if (PRESC_W >= (1 << LG_W)) begin : g_bad_lg
    $error("Exponent width cannot hold the prescaler width.");
  end

  // Both counters end an interval by wrapping, so the limit must be all ones.
  if (COUNT_MAX != {COUNT_W{1'b1}}) begin : g_bad_count
    $error("Interval count limit must fill the counter width.");
  end

  // Only byte lane 0 is decoded, so every field must sit in its low bits.
  if (WB_DW < 8 || MODE_RESTART_BIT > 7 ||
      MODE_SEL_LSB + MODE_SEL_W > MODE_RESTART_BIT) begin : g_bad_mode
    $error("Mode fields must sit below the restart bit in byte lane 0.");
  end

  if (STAT_W > 8 || STAT_OVF_BIT >= STAT_W || STAT_WAIT_BIT >= STAT_W ||
      STAT_OVF_BIT == STAT_WAIT_BIT) begin : g_bad_stat
    $error("Status bits must be distinct and lie inside byte lane 0.");
  end

  if (MODE_OFS[1:0] != 2'h0 || COUNT_OFS[1:0] != 2'h0 ||
      STAT_OFS[1:0] != 2'h0 || MASK_OFS[1:0] != 2'h0) begin : g_bad_ofs
    $error("Register offsets must be word aligned.");
  end

  // The reset wait must use a listed code rather than the fallback decode.
  if (RESET_WAIT_SEL != SEL_DIV4096 && RESET_WAIT_SEL != SEL_DIV512 &&
      RESET_WAIT_SEL != SEL_DIV128 && RESET_WAIT_SEL != SEL_DIV32) begin : g_bad_rst_sel
    $error("The reset wait must use one of the listed select codes.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Maps a select code to its divider exponent.
  function automatic logic [LG_W-1:0] sel_to_log2(input logic [MODE_SEL_W-1:0] code);
    logic [LG_W-1:0] lg;
    lg = LG_W'(TAP_000_LOG2);
    unique case (code)
      SEL_DIV512: lg = LG_W'(TAP_011_LOG2);
      SEL_DIV128: lg = LG_W'(TAP_101_LOG2);
      SEL_DIV32:  lg = LG_W'(TAP_111_LOG2);
      default:    lg = LG_W'(TAP_000_LOG2);
    endcase
    return lg;
  endfunction : sel_to_log2

  // A tap pulses once every 2^lg cycles, when its low prescaler bits are all one.
  function automatic logic tap_hit(input logic [PRESC_W-1:0] presc,
                                   input logic [LG_W-1:0]    lg);
    logic hit;
    hit = 1'b1;
    for (int i = 0; i < PRESC_W; i++) begin
      if (i < int'(lg) && !presc[i]) begin
        hit = 1'b0;
      end
    end
    return hit;
  endfunction : tap_hit

  // Register select; offsets are whole bytes, so the full address is compared.
  function automatic logic reg_hit(input logic [WB_AW-1:0] adr,
                                   input logic [WB_AW-1:0] ofs);
    return adr == ofs;
  endfunction : reg_hit

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic                  ack_ff;
  logic [WB_DW-1:0]      dat_ff;
  logic [WB_DW-1:0]      nxt_dat;
  logic                  req;
  logic                  fire;
  logic                  wr_lane0;
  logic                  rd_fire;
  logic                  mode_wr;
  logic                  restart;
  logic                  mode_hit;
  logic                  mask_wr;
  logic                  stat_rd;
  logic                  wake_start;

  logic [MODE_SEL_W-1:0] mode_sel_ff;
  logic [PRESC_W-1:0]    presc_ff;
  logic [COUNT_W-1:0]    count_ff;
  logic                  flag_ff;
  logic [LG_W-1:0]       cur_lg;
  logic                  bt_tick;
  logic                  overflow;

  wait_state_t           state_ff;
  logic [LG_W-1:0]       wait_lg_ff;
  logic [COUNT_W-1:0]    wait_cnt_ff;
  logic                  wait_tick;
  logic                  wait_done;

  logic [STAT_W-1:0]     status_ff;
  logic [STAT_W-1:0]     mask_ff;
  logic [STAT_W-1:0]     stat_set;
  logic [STAT_W-1:0]     stat_clr;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave.

  // The answer is registered so read data comes from a flip-flop; the access
  // takes effect on the edge where the master samples ack. A request is
  // answered in the cycle after it is first seen; a master that keeps cyc and
  // stb up after ack is answered again every second cycle.
  assign req      = wb_req_i.cyc & wb_req_i.stb;
  assign fire     = req & ack_ff;
  assign wr_lane0 = fire & wb_req_i.we & wb_req_i.sel[0];
  assign rd_fire  = fire & ~wb_req_i.we;
  assign mode_hit = reg_hit(wb_req_i.adr, MODE_OFS);
  assign mode_wr  = wr_lane0 & mode_hit;
  assign mask_wr  = wr_lane0 & reg_hit(wb_req_i.adr, MASK_OFS);
  assign stat_rd  = rd_fire & reg_hit(wb_req_i.adr, STAT_OFS);

  // Any write that sets the restart bit restarts; a single-bit set
  // instruction maps onto a byte-lane-0 write here.
  assign restart  = mode_wr & wb_req_i.dat[MODE_RESTART_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // Unmapped offsets answer with zero data and ignore writes.
  always_comb begin
    nxt_dat = '0;
    unique case (wb_req_i.adr)
      MODE_OFS:  nxt_dat[MODE_SEL_W-1:0] = mode_sel_ff; // Restart bit reads zero.
      COUNT_OFS: nxt_dat[COUNT_W-1:0]    = count_ff;
      STAT_OFS:  nxt_dat[STAT_W-1:0]     = status_ff;
      MASK_OFS:  nxt_dat[STAT_W-1:0]     = mask_ff;
      default:   nxt_dat = '0;
    endcase
  end

  // Read data is captured on the request edge and held through the answer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= '0;
    end else if (req && !ack_ff) begin
      dat_ff <= nxt_dat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Mode and mask registers.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_sel_ff <= MODE_SEL_RST;
    end else if (mode_wr) begin
      mode_sel_ff <= wb_req_i.dat[MODE_SEL_LSB +: MODE_SEL_W];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_ff <= MASK_RST;
    end else if (mask_wr) begin
      mask_ff <= wb_req_i.dat[STAT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and interval counter.

  // One free-running prescaler serves every tap. A new select code takes
  // effect at the next pulse of the new tap, so the interval running at the
  // change is neither old nor new length; restart to get a clean one.
  assign cur_lg  = sel_to_log2(mode_sel_ff);
  assign bt_tick = tap_hit(presc_ff, cur_lg);

  // A restart wins over a tick in the same cycle, so no overflow is reported
  // for a count that software has just thrown away.
  assign overflow = bt_tick & (count_ff == COUNT_MAX) & ~restart;

  // Restart also clears the prescaler so the first interval is a full one.
  always_ff @(posedge clk_i) begin
    if (rst_i || restart) begin
      presc_ff <= '0;
    end else begin
      presc_ff <= presc_ff + PRESC_W'(1);
    end
  end

  // The counter wraps naturally, so an interval run under one select code is exactly 256 tap
  // pulses long and equals the stabilization time of that code.
  always_ff @(posedge clk_i) begin
    if (rst_i || restart) begin
      count_ff <= COUNT_RST;
    end else if (bt_tick) begin
      count_ff <= count_ff + COUNT_W'(1);
    end
  end

  // Request flag: the interrupt controller acknowledges it; a new overflow
  // in the acknowledge cycle keeps it set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_ff <= 1'b0;
    end else if (overflow) begin
      flag_ff <= 1'b1;
    end else if (restart || interval_irq_ack_i) begin
      flag_ff <= 1'b0;
    end
  end

  assign interval_irq_flag_o = flag_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillation stabilization wait.

  // The wait is 256 pulses of the tap chosen when it began, so a later change
  // of the mode register does not stretch a wait in progress.
  assign wait_tick = tap_hit(presc_ff, wait_lg_ff);
  assign wait_done = (state_ff == ST_WAIT) & wait_tick & (wait_cnt_ff == COUNT_MAX);

  // Only a running clock can be stopped, so a wake request during a wait is
  // ignored and the wait already under way keeps its own length.
  assign wake_start = (state_ff == ST_RUN) & stop_mode_i & wake_irq_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_WAIT;
    end else begin
      unique case (state_ff)
        ST_RUN: begin
          if (wake_start) begin
            state_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (wait_done) begin
            state_ff <= ST_RUN;
          end
        end
        default: state_ff <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_lg_ff <= sel_to_log2(RESET_WAIT_SEL);
    end else if (wake_start) begin
      wait_lg_ff <= cur_lg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_ff == ST_RUN) begin
      wait_cnt_ff <= COUNT_RST;
    end else if (wait_tick) begin
      wait_cnt_ff <= wait_cnt_ff + COUNT_W'(1);
    end
  end

  assign sys_clk_hold_o = (state_ff == ST_WAIT);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status.

  always_comb begin
    stat_set                = '0;
    stat_set[STAT_OVF_BIT]  = overflow;
    stat_set[STAT_WAIT_BIT] = wait_done;
  end

  // Only the bits that the read actually returned are cleared, so an event
  // that lands during the access is kept for the next read.
  assign stat_clr = stat_rd ? dat_ff[STAT_W-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_ff <= STAT_RST;
    end else begin
      status_ff <= (status_ff & ~stat_clr) | stat_set;
    end
  end

  // The line follows status and mask directly, so unmasking a pending event
  // raises it in the cycle after the mask write lands.
  assign irq_o = |(status_ff & mask_ff);

endmodule : basic_interval_timer

// ==== basic_interval_timer_pkg.sv ====
// Purpose: Shared constants and types for the basic interval timer.
// Assumes: Classic Wishbone slave with 32-bit data and byte addressing.
// Notes:   Each register takes one aligned word; narrow fields sit in the low bits.

package basic_interval_timer_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry.
  localparam int unsigned WB_AW = 8;
  localparam int unsigned WB_DW = 32;
  localparam int unsigned WB_SW = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [WB_AW-1:0] MODE_OFS  = 8'h00;
  localparam logic [WB_AW-1:0] COUNT_OFS = 8'h04;
  localparam logic [WB_AW-1:0] STAT_OFS  = 8'h08;
  localparam logic [WB_AW-1:0] MASK_OFS  = 8'h0C;

  ////////////////////////////////////////////////////////////////////////////
  // Mode register layout and reset value.
  localparam int unsigned MODE_RESTART_BIT = 3;
  localparam int unsigned MODE_SEL_LSB     = 0;
  localparam int unsigned MODE_SEL_W       = 3;
  localparam logic [MODE_SEL_W-1:0] MODE_SEL_RST = 3'h0;

  // Clock-select codes.
  localparam logic [MODE_SEL_W-1:0] SEL_DIV4096 = 3'h0;
  localparam logic [MODE_SEL_W-1:0] SEL_DIV512  = 3'h3;
  localparam logic [MODE_SEL_W-1:0] SEL_DIV128  = 3'h5;
  localparam logic [MODE_SEL_W-1:0] SEL_DIV32   = 3'h7;

  // The wait after reset uses the 2^17-cycle setting.
  localparam logic [MODE_SEL_W-1:0] RESET_WAIT_SEL = SEL_DIV512;

  ////////////////////////////////////////////////////////////////////////////
  // Interval counter: 256 tap pulses make one interval.
  localparam int unsigned          COUNT_W   = 8;
  localparam logic [COUNT_W-1:0]   COUNT_MAX = 8'hFF;
  localparam logic [COUNT_W-1:0]   COUNT_RST = 8'h00;

  // Prescaler width covers the largest divider, 2^12.
  localparam int unsigned PRESC_W = 12;
  localparam int unsigned LG_W    = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Status and mask layout.
  localparam int unsigned       STAT_W        = 2;
  localparam int unsigned       STAT_OVF_BIT  = 0;
  localparam int unsigned       STAT_WAIT_BIT = 1;
  localparam logic [STAT_W-1:0] STAT_RST      = 2'h0;
  localparam logic [STAT_W-1:0] MASK_RST      = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_WAIT = 2'b10
  } wait_state_t;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [WB_AW-1:0] adr;
    logic [WB_SW-1:0] sel;
    logic [WB_DW-1:0] dat;
  } wb_req_t;

endpackage : basic_interval_timer_pkg

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the basic interval timer.
// Assumes: Taps shortened to 4,3,2,1 so waits stay short.
// Notes:   Tap restart jitter is allowed a few cycles of slack.
`timescale 1ns/10ps
module tb_top;
  import basic_interval_timer_pkg::*;
  logic             clk_i, rst_i, stop_mode_i, wake_irq_i, interval_irq_ack_i;
  wb_req_t          wb_req_i;
  logic             wb_ack_o, interval_irq_flag_o, sys_clk_hold_o, irq_o;
  logic [WB_DW-1:0] wb_dat_o;
  int               failures, comparisons;
  logic [3:0]       wb_sel = 4'h1;
  int               lgs [5] = '{4, 3, 2, 1, 4};
  logic [2:0]       codes [5] = '{3'h0, 3'h3, 3'h5, 3'h7, 3'h2};

  basic_interval_timer #(.TAP_000_LOG2(4), .TAP_011_LOG2(3), .TAP_101_LOG2(2), .TAP_111_LOG2(1)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .stop_mode_i(stop_mode_i), .wake_irq_i(wake_irq_i), .interval_irq_ack_i(interval_irq_ack_i),
    .interval_irq_flag_o(interval_irq_flag_o), .sys_clk_hold_o(sys_clk_hold_o), .irq_o(irq_o));

  //////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: wb_sel, dat: d};
    n = 0;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin failures++; close_out(); end
    q = wb_dat_o;
    wb_req_i.cyc <= 1'b0;
    wb_req_i.stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // Waits for the flag to rise (flag=1) or the hold to drop (flag=0).
  task automatic wait_on(input logic flag, output int n);
    n = 0;
    do begin @(posedge clk_i); n++; end
    while ((flag ? interval_irq_flag_o !== 1'b1 : sys_clk_hold_o !== 1'b0) && n < 10000);
    if (n >= 10000) begin failures++; close_out(); end
  endtask : wait_on

  task automatic near(input string what, input int n, input int exp);
    chk(what, 32'(n >= exp - 6 && n <= exp + 6), 32'h1);
  endtask : near

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    int n;
    logic [31:0] q;
    chk("hold", sys_clk_hold_o, 1);
    wb(0, MODE_OFS, 0, q);
    chk("mode reset", q, 0);
    wait_on(0, n);
    near("reset wait", n + 4, 256 << 3);
    $display("test reset done");
  endtask : t_reset

  task automatic t_periods();
    int n;
    logic [31:0] q;
    for (int i = 0; i < 5; i++) begin
      wb(1, MODE_OFS, {28'h0, 1'b1, codes[i]}, q);
      wb(0, MODE_OFS, 0, q);
      chk("mode", q, {29'h0, codes[i]});
      wait_on(1, n);
      near("period", n + 2, 256 << lgs[i]);
      interval_irq_ack_i <= 1'b1;
      @(posedge clk_i);
      interval_irq_ack_i <= 1'b0;
      @(posedge clk_i);
      chk("flag ack", interval_irq_flag_o, 0);
      wait_on(1, n);
      near("next period", n + 2, 256 << lgs[i]);
    end
    $display("test periods done");
  endtask : t_periods

  task automatic t_count();
    logic [31:0] q, p;
    int k;
    wb(1, MODE_OFS, 32'h8, q);
    wb(1, COUNT_OFS, 32'hFF, q);
    k = 0;
    do begin wb(0, COUNT_OFS, 0, p); wb(0, COUNT_OFS, 0, q); k++; end while (p !== q && k < 4);
    chk("count after restart", q, 0);
    wb(0, 8'h10, 0, q);
    chk("unmapped", q, 0);
    wb_sel = 4'h2;
    wb(1, MODE_OFS, 32'h7, q);
    wb_sel = 4'h1;
    wb(0, MODE_OFS, 0, q);
    chk("lane 0 only", q, 0);
    $display("test count done");
  endtask : t_count

  task automatic t_irq_wake();
    int n;
    logic [31:0] q;
    wb(1, MODE_OFS, 32'hF, q);
    wb(0, STAT_OFS, 0, q);
    wait_on(1, n);
    chk("irq masked", irq_o, 0);
    wb(1, MASK_OFS, 32'h3, q);
    chk("irq on", irq_o, 1);
    wb(0, STAT_OFS, 0, q);
    chk("overflow status", q[0], 1);
    chk("irq cleared", irq_o, 0);
    stop_mode_i <= 1'b1;
    wake_irq_i <= 1'b1;
    @(posedge clk_i);
    wake_irq_i <= 1'b0;
    @(posedge clk_i);
    chk("wake hold", sys_clk_hold_o, 1);
    wait_on(0, n);
    near("wake wait", n + 1, 256 << 1);
    stop_mode_i <= 1'b0;
    chk("irq wake", irq_o, 1);
    wb(0, STAT_OFS, 0, q);
    chk("wait status", q[1], 1);
    $display("test irq and wake done");
  endtask : t_irq_wake

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial begin
    rst_i = 1'b1;
    stop_mode_i = 1'b0;
    wake_irq_i = 1'b0;
    interval_irq_ack_i = 1'b0;
    wb_req_i = '0;
    failures = 0;
    comparisons = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_periods();
    t_count();
    t_irq_wake();
    close_out();
  end
endmodule : tb_top

// ==== timer_checker_assertions.sv ====
// Purpose: Port-level checks for the basic interval timer.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound into every timer instance.
`timescale 1ns/10ps
module timer_checker (
  input wire logic                                  clk_i,
  input wire logic                                  rst_i,
  input wire basic_interval_timer_pkg::wb_req_t     wb_req_i,
  input wire logic                                  wb_ack_o,
  input wire logic [basic_interval_timer_pkg::WB_DW-1:0] wb_dat_o,
  input wire logic                                  stop_mode_i,
  input wire logic                                  wake_irq_i,
  input wire logic                                  interval_irq_flag_o,
  input wire logic                                  sys_clk_hold_o
);
  import basic_interval_timer_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req_w;
  logic rd_w;
  logic restart_w;
  assign req_w = wb_req_i.cyc & wb_req_i.stb;
  assign rd_w = wb_ack_o & req_w & !wb_req_i.we;
  assign restart_w = wb_ack_o & req_w & wb_req_i.we & wb_req_i.sel[0] &
                     (wb_req_i.adr == MODE_OFS) & wb_req_i.dat[MODE_RESTART_BIT];
  //////////////////////////////////////////////////////////////////////////////
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_resp; req_w && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack one cycle after request");
  property p_restart; restart_w |=> !interval_irq_flag_o [*8]; endproperty
  a_restart: assert property (p_restart) else $error("flag set after restart");
  property p_count_ro; rd_w && wb_req_i.adr == COUNT_OFS |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_count_ro: assert property (p_count_ro) else $error("count wider than 8 bits");
  property p_mode_rd; rd_w && wb_req_i.adr == MODE_OFS |-> wb_dat_o[31:3] == 29'h0; endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("restart bit reads back");
  property p_unmapped; rd_w && wb_req_i.adr > MASK_OFS |-> wb_dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_wake; !sys_clk_hold_o && stop_mode_i && wake_irq_i |=> sys_clk_hold_o; endproperty
  a_wake: assert property (p_wake) else $error("wake did not hold clock");
  property p_reset_hold; $fell(rst_i) |-> sys_clk_hold_o; endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("no wait after reset");
  c_restart: cover property (restart_w);
  c_flag: cover property ($rose(interval_irq_flag_o));
  c_wake_end: cover property ($fell(sys_clk_hold_o));
endmodule : timer_checker

bind basic_interval_timer timer_checker chk_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .stop_mode_i(stop_mode_i), .wake_irq_i(wake_irq_i),
  .interval_irq_flag_o(interval_irq_flag_o), .sys_clk_hold_o(sys_clk_hold_o));
